// ==== pkg/spc_defines.vh ====
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// ****************************************
// Bus and packet constants
// ****************************************
`define SPC_ADDR_W        7
`define SPC_DEF_ADDR      7'h28
`define SPC_BIT_CNT_W     4
`define SPC_BYTE_BITS     4'h8
`define SPC_BIT_ACK       4'h9
`define SPC_DIR_READ      1'b1
`define SPC_DIR_WRITE     1'b0
`define SPC_PRESS_W       14
`define SPC_TEMP_W        11
`define SPC_TEMP_HI_W     8
`define SPC_TEMP_LO_PAD   5'h00
`define SPC_BYTE_IDX_W    2
`define SPC_BYTE_PRESS_HI 2'h0
`define SPC_BYTE_PRESS_LO 2'h1
`define SPC_BYTE_TEMP_HI  2'h2
`define SPC_BYTE_TEMP_LO  2'h3

// ****************************************
// Status codes
// ****************************************
`define SPC_ST_FRESH      2'h0
`define SPC_ST_INVALID    2'h1
`define SPC_ST_STALE      2'h2
`define SPC_ST_DIAG       2'h3

// ****************************************
// Measurement kinds
// ****************************************
`define SPC_MEAS_FULL     1'b1
`define SPC_MEAS_BRIDGE   1'b0

`endif

// ==== hdl/spc_pin_sync.v ====
`timescale 1ns/100ps
`include "spc_defines.vh"

// ****************************************
// Two-flop synchroniser with edge detect
// ****************************************
module spc_pin_sync
(
    clk,
    resetn,
    pin_in,
    level_out,
    rise_out,
    fall_out
);
    input  wire clk;
    input  wire resetn;
    input  wire pin_in;
    output wire level_out;
    output wire rise_out;
    output wire fall_out;

    reg meta_r;
    reg sync_r;
    reg last_r;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
            last_r <= 1'b1;
        end
        else
        begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign level_out = sync_r;
    assign rise_out  = sync_r & ~last_r;
    assign fall_out  = ~sync_r & last_r;

endmodule // spc_pin_sync

// ==== hdl/spc_cmd_port.v ====
`timescale 1ns/100ps
`include "spc_defines.vh"

// Notes on behaviour
// - Address with read bit one is a read; device acknowledges it.
// - Address with write bit zero is a write; device acknowledges it.
// - Device drives acknowledge after its own address in either direction.
// - In sleep, read request wakes device for full measurement cycle.
// - Two- or three-byte fetch also acts as a read request.
// - Write request wakes device for bridge-only measurement with stored values.
// - In sleep, a write with data bytes counts as write request.
// - Device keeps sending bytes; controller ends with NACK and stop.
// - Three-byte fetch: two pressure bytes with status, one temperature byte.
// - Fourth byte completes 11-bit temperature; low five bits undefined.
// - Pressure sits in bits thirteen to zero below the status.
// - Two status bits are the top bits of the first byte.
// - Status 00 on first fetch after a completed measurement.
// - Status 01 flags an invalid device state.
// - Status 10 once a fetch already served since last measurement.
// - Fetch before or during first measurement after reset reads 10.
// - Status 11 flags a diagnostic fault.
// - Completed fetch turns stored status stale until new result.
// - Fetch while measurement runs returns stale status.
// - Write request first after power-on is still flagged valid.
module spc_cmd_port
(
    clk,
    resetn,
    dev_addr,
    sleep_mode,
    scl_in,
    sda_in,
    sda_out,
    sda_oe,
    meas_start,
    meas_kind,
    meas_busy,
    meas_done,
    meas_pressure,
    meas_temp,
    fault_invalid,
    fault_diag,
    status_code,
    fetch_active
);
    input  wire                          clk;
    input  wire                          resetn;
    input  wire [`SPC_ADDR_W-1:0]        dev_addr;
    input  wire                          sleep_mode;
    input  wire                          scl_in;
    input  wire                          sda_in;
    output wire                          sda_out;
    output wire                          sda_oe;
    output reg                           meas_start;
    output reg                           meas_kind;
    input  wire                          meas_busy;
    input  wire                          meas_done;
    input  wire [`SPC_PRESS_W-1:0]       meas_pressure;
    input  wire [`SPC_TEMP_W-1:0]        meas_temp;
    input  wire                          fault_invalid;
    input  wire                          fault_diag;
    output reg  [1:0]                    status_code;
    output reg                           fetch_active;

    // ****************************************
    // States
    // ****************************************
    localparam [2:0] ST_IDLE    = 3'd0;
    localparam [2:0] ST_ADDR    = 3'd1;
    localparam [2:0] ST_AACK    = 3'd2;
    localparam [2:0] ST_TX      = 3'd3;
    localparam [2:0] ST_TACK    = 3'd4;
    localparam [2:0] ST_RX      = 3'd5;
    localparam [2:0] ST_RACK    = 3'd6;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    wire scl_lvl;
    wire scl_rise;
    wire scl_fall;
    wire sda_lvl;
    wire sda_rise;
    wire sda_fall;

    spc_pin_sync u_scl
    (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    (scl_in),
        .level_out (scl_lvl),
        .rise_out  (scl_rise),
        .fall_out  (scl_fall)
    );

    spc_pin_sync u_sda
    (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    (sda_in),
        .level_out (sda_lvl),
        .rise_out  (sda_rise),
        .fall_out  (sda_fall)
    );

    wire start_cond = sda_fall & scl_lvl;
    wire stop_cond  = sda_rise & scl_lvl;

    // ****************************************
    // Registers
    // ****************************************
    reg [2:0]                     state_r;
    reg [`SPC_BIT_CNT_W-1:0]      bit_cnt_r;
    reg [7:0]                     shift_r;
    reg [`SPC_BYTE_IDX_W-1:0]     byte_idx_r;
    reg                           sda_drive_low_r;
    reg                           dir_read_r;
    reg                           addr_hit_r;
    reg                           served_r;
    reg                           data_valid_r;
    reg [`SPC_PRESS_W-1:0]        press_r;
    reg [`SPC_TEMP_W-1:0]         temp_r;
    reg                           fetch_done_r;

    // ****************************************
    // Status encode
    // ****************************************
    reg [1:0] status_nxt;

    always @*
    begin
        if (fault_diag)
            status_nxt = `SPC_ST_DIAG;
        else if (fault_invalid)
            status_nxt = `SPC_ST_INVALID;
        else if (meas_busy || !data_valid_r)
            status_nxt = `SPC_ST_STALE;
        else if (served_r)
            status_nxt = `SPC_ST_STALE;
        else
            status_nxt = `SPC_ST_FRESH;
    end

    // ****************************************
    // Outgoing byte select
    // ****************************************
    reg [7:0] tx_byte;

    always @*
    begin
        if (byte_idx_r == `SPC_BYTE_PRESS_HI)
            tx_byte = {status_code, press_r[`SPC_PRESS_W-1:8]};
        else if (byte_idx_r == `SPC_BYTE_PRESS_LO)
            tx_byte = press_r[7:0];
        else if (byte_idx_r == `SPC_BYTE_TEMP_HI)
            tx_byte = temp_r[`SPC_TEMP_W-1:`SPC_TEMP_W-`SPC_TEMP_HI_W];
        else
            tx_byte = {temp_r[2:0], `SPC_TEMP_LO_PAD};
    end

    // ****************************************
    // Next byte lookahead
    // ****************************************
    wire [`SPC_BYTE_IDX_W-1:0] idx_next = (byte_idx_r == `SPC_BYTE_TEMP_LO) ?
                                          byte_idx_r : byte_idx_r + 1'b1;
    wire [7:0] tx_byte_next = (idx_next == `SPC_BYTE_PRESS_LO) ? press_r[7:0] :
                              (idx_next == `SPC_BYTE_TEMP_HI)  ?
                              temp_r[`SPC_TEMP_W-1:`SPC_TEMP_W-`SPC_TEMP_HI_W] :
                              (idx_next == `SPC_BYTE_TEMP_LO)  ?
                              {temp_r[2:0], `SPC_TEMP_LO_PAD} : tx_byte;

    // ****************************************
    // Protocol engine
    // ****************************************
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            state_r         <= ST_IDLE;
            bit_cnt_r       <= {`SPC_BIT_CNT_W{1'b0}};
            shift_r         <= 8'h00;
            byte_idx_r      <= `SPC_BYTE_PRESS_HI;
            sda_drive_low_r <= 1'b0;
            dir_read_r      <= 1'b0;
            addr_hit_r      <= 1'b0;
            served_r        <= 1'b0;
            data_valid_r    <= 1'b0;
            press_r         <= {`SPC_PRESS_W{1'b0}};
            temp_r          <= {`SPC_TEMP_W{1'b0}};
            meas_start      <= 1'b0;
            meas_kind       <= `SPC_MEAS_FULL;
            status_code     <= `SPC_ST_STALE;
            fetch_active    <= 1'b0;
            fetch_done_r    <= 1'b0;
        end
        else
        begin
            meas_start <= 1'b0;
            // New result stored: fresh again, set wins over fetch completion
            if (meas_done)
            begin
                press_r      <= meas_pressure;
                temp_r       <= meas_temp;
                data_valid_r <= 1'b1;
                served_r     <= 1'b0;
            end
            else if (fetch_done_r)
                served_r <= 1'b1;
            fetch_done_r <= 1'b0;

            if (stop_cond || start_cond)
            begin
                // Address-only or data write in sleep becomes bridge request
                if (addr_hit_r && !dir_read_r && sleep_mode)
                begin
                    meas_start <= 1'b1;
                    meas_kind  <= `SPC_MEAS_BRIDGE;
                end
                // Read address, or short fetch, in sleep becomes full request
                if (addr_hit_r && dir_read_r && sleep_mode &&
                    byte_idx_r != `SPC_BYTE_TEMP_LO)
                begin
                    meas_start <= 1'b1;
                    meas_kind  <= `SPC_MEAS_FULL;
                end
                if (addr_hit_r && dir_read_r && fetch_active)
                    fetch_done_r <= 1'b1;
                addr_hit_r      <= 1'b0;
                fetch_active    <= 1'b0;
                sda_drive_low_r <= 1'b0;
                bit_cnt_r       <= {`SPC_BIT_CNT_W{1'b0}};
                state_r         <= start_cond ? ST_ADDR : ST_IDLE;
            end
            else
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        sda_drive_low_r <= 1'b0;
                    end
                    ST_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shift_r   <= {shift_r[6:0], sda_lvl};
                            bit_cnt_r <= bit_cnt_r + 1'b1;
                        end
                        else if (scl_fall && bit_cnt_r == `SPC_BYTE_BITS)
                        begin
                            if (shift_r[7:1] == dev_addr)
                            begin
                                sda_drive_low_r <= 1'b1;
                                addr_hit_r      <= 1'b1;
                                dir_read_r      <= (shift_r[0] == `SPC_DIR_READ);
                                state_r         <= ST_AACK;
                            end
                            else
                                state_r <= ST_IDLE;
                        end
                    end
                    ST_AACK:
                    begin
                        if (scl_fall)
                        begin
                            bit_cnt_r <= {`SPC_BIT_CNT_W{1'b0}};
                            if (dir_read_r)
                            begin
                                // Status latched for the packet; later bytes read press_r and temp_r live
                                status_code     <= status_nxt;
                                byte_idx_r      <= `SPC_BYTE_PRESS_HI;
                                fetch_active    <= 1'b1;
                                shift_r         <= {status_nxt, press_r[`SPC_PRESS_W-1:8]};
                                sda_drive_low_r <= ~status_nxt[1];
                                state_r         <= ST_TX;
                            end
                            else
                            begin
                                sda_drive_low_r <= 1'b0;
                                state_r         <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (bit_cnt_r == `SPC_BYTE_BITS - 4'h1)
                            begin
                                sda_drive_low_r <= 1'b0;
                                state_r         <= ST_TACK;
                            end
                            else
                            begin
                                sda_drive_low_r <= ~shift_r[6];
                                shift_r         <= {shift_r[6:0], 1'b0};
                                bit_cnt_r       <= bit_cnt_r + 1'b1;
                            end
                        end
                    end
                    ST_TACK:
                    begin
                        if (scl_rise)
                        begin
                            if (sda_lvl)
                                state_r <= ST_IDLE;
                        end
                        else if (scl_fall)
                        begin
                            // Keep streaming; fourth index repeats past end
                            if (byte_idx_r != `SPC_BYTE_TEMP_LO)
                                byte_idx_r <= byte_idx_r + 1'b1;
                            bit_cnt_r <= {`SPC_BIT_CNT_W{1'b0}};
                            state_r   <= ST_TX;
                        end
                    end
                    ST_RX:
                    begin
                        if (scl_rise)
                            bit_cnt_r <= bit_cnt_r + 1'b1;
                        else if (scl_fall && bit_cnt_r == `SPC_BYTE_BITS)
                        begin
                            sda_drive_low_r <= 1'b1;
                            state_r         <= ST_RACK;
                        end
                    end
                    ST_RACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_drive_low_r <= 1'b0;
                            bit_cnt_r       <= {`SPC_BIT_CNT_W{1'b0}};
                            state_r         <= ST_RX;
                        end
                    end
                    default:
                    begin
                        state_r <= ST_IDLE;
                    end
                endcase
                // Load next byte at the start of each transmit byte after the first
                if (state_r == ST_TACK && scl_fall)
                begin
                    sda_drive_low_r <= ~tx_byte_next[7];
                    shift_r         <= tx_byte_next;
                end
            end
        end
    end

    // ****************************************
    // Open-drain data pin
    // ****************************************
    assign sda_out = 1'b0;
    assign sda_oe  = sda_drive_low_r;

endmodule // spc_cmd_port

// ==== bench/spc_cmd_port_monitor.sv ====
`timescale 1ns/100ps
// ****
// Port checker
// ****
module spc_cmd_port_monitor
(
    input logic       clk,
    input logic       resetn,
    input logic       sleep_mode,
    input logic       scl_in,
    input logic       sda_oe,
    input logic       meas_start,
    input logic       meas_busy,
    input logic       meas_done,
    input logic       fault_invalid,
    input logic       fault_diag,
    input logic [1:0] status_code,
    input logic       fetch_active
);
    logic fresh_r;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Result not yet served by a fetch
    always @(posedge clk)
        fresh_r <= resetn && (meas_done || (fresh_r && !$fell(fetch_active)));
    property p_reset;
        disable iff (1'b0) !resetn |=> !sda_oe && !fetch_active && !meas_start && status_code == 2'h2;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
    property p_pulse;
        meas_start |=> !meas_start;
    endproperty
    a_pulse: assert property (p_pulse) else $error("start pulse too long");
    property p_sda_steady;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    a_sda_steady: assert property (p_sda_steady) else $error("data moved with clock high");
    property p_sleep_only;
        meas_start |-> sleep_mode;
    endproperty
    a_sleep_only: assert property (p_sleep_only) else $error("request outside sleep");
    property p_after_stop;
        meas_start |-> scl_in && !fetch_active;
    endproperty
    a_after_stop: assert property (p_after_stop) else $error("request before stop");
    property p_latched;
        fetch_active [*5] |-> $stable(status_code);
    endproperty
    a_latched: assert property (p_latched) else $error("status moved in packet");
    property p_fresh;
        $rose(fetch_active) && fresh_r && !meas_busy && !fault_invalid && !fault_diag
            |-> ##[0:2] status_code == 2'h0;
    endproperty
    a_fresh: assert property (p_fresh) else $error("fresh status wrong");
    property p_stale;
        $rose(fetch_active) && !(fresh_r && !meas_busy) && !fault_invalid && !fault_diag
            |-> ##[0:2] status_code == 2'h2;
    endproperty
    a_stale: assert property (p_stale) else $error("stale status wrong");
    property p_diag;
        $rose(fetch_active) && fault_diag |-> ##[0:2] status_code == 2'h3;
    endproperty
    a_diag: assert property (p_diag) else $error("diagnostic status wrong");
endmodule // spc_cmd_port_monitor

bind spc_cmd_port spc_cmd_port_monitor i_mon
(
    .clk(clk), .resetn(resetn), .sleep_mode(sleep_mode), .scl_in(scl_in),
    .sda_oe(sda_oe), .meas_start(meas_start), .meas_busy(meas_busy), .meas_done(meas_done),
    .fault_invalid(fault_invalid), .fault_diag(fault_diag), .status_code(status_code),
    .fetch_active(fetch_active)
);

// ==== bench/spc_i2c_ctrl.sv ====
`timescale 1ns/100ps
// ****
// Bus controller model
// ****
module spc_i2c_ctrl
(
    input  wire logic  clk,
    input  wire logic  sda_line,
    output logic       scl,
    output logic       sda_drv,
    output logic       got_stb,
    output logic [8:0] got_val
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
        got_stb = 1'b0;
        got_val = 9'h000;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One bit: data set mid-low, sampled mid-high
    task automatic bit_x(input logic b, output logic s);
        hold(5);
        sda_drv <= b;
        hold(5);
        scl <= 1'b1;
        hold(5);
        s = sda_line;
        hold(5);
        scl <= 1'b0;
    endtask
    task automatic note(input logic [8:0] v);
        got_val <= v;
        got_stb <= 1'b1;
        hold(1);
        got_stb <= 1'b0;
    endtask
    task automatic start();
        sda_drv <= 1'b1;
        hold(5);
        scl <= 1'b1;
        hold(5);
        sda_drv <= 1'b0;
        hold(5);
        scl <= 1'b0;
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        hold(5);
        scl <= 1'b1;
        hold(5);
        sda_drv <= 1'b1;
        hold(5);
    endtask
    task automatic wr_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_x(b[i], s);
        bit_x(1'b1, s);
        note({1'b1, 7'h00, s});
    endtask
    task automatic rd_byte(input logic last);
        logic [7:0] d;
        logic       s;
        for (int i = 7; i >= 0; i--)
            bit_x(1'b1, d[i]);
        bit_x(last, s);
        note({1'b0, d});
    endtask
endmodule // spc_i2c_ctrl

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
`include "spc_defines.vh"
// ****
// Bench top
// ****
module testbench;
    logic              clk = 1'b0;
    logic              resetn = 1'b0;
    logic [6:0]        dev_addr = `SPC_DEF_ADDR;
    logic              sleep_mode = 1'b1;
    logic              meas_busy = 1'b0;
    logic              meas_done = 1'b0;
    logic [13:0]       meas_pressure = 14'h0000;
    logic [10:0]       meas_temp = 11'h000;
    logic              fault_invalid = 1'b0;
    logic              fault_diag = 1'b0;
    wire               scl, sda_drv, sda_out, sda_oe, meas_start, meas_kind, fetch_active;
    wire               got_stb;
    wire [1:0]         status_code;
    wire [8:0]         got_val;
    wire               sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
    logic [16:0]       exp_q[$];
    logic              exp_m[$];
    logic [16:0]       nt;
    logic [8:0]        msk;
    logic              fresh = 1'b0;
    logic              valid = 1'b0;
    logic [2:0]        tbl[4] = '{3'b010, 3'b001, 3'b011, 3'b100};
    int                mismatches = 0;
    int                samples_checked = 0;
    int                cycles = 0;
    int                seed;
    always #20 clk = ~clk;
    spc_cmd_port i_dut
    (
        .clk(clk), .resetn(resetn), .dev_addr(dev_addr), .sleep_mode(sleep_mode),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .meas_start(meas_start), .meas_kind(meas_kind), .meas_busy(meas_busy),
        .meas_done(meas_done), .meas_pressure(meas_pressure), .meas_temp(meas_temp),
        .fault_invalid(fault_invalid), .fault_diag(fault_diag),
        .status_code(status_code), .fetch_active(fetch_active)
    );
    spc_i2c_ctrl i_ctrl
    (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv),
        .got_stb(got_stb), .got_val(got_val)
    );
    task automatic check(input logic [8:0] seen, input logic [8:0] want);
        samples_checked++;
        if (seen !== want)
        begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, want);
        end
    endtask
    task automatic finish_test();
        check(9'(exp_q.size() + exp_m.size()), 9'h000);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset();
        resetn <= 1'b0;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        fresh = 1'b0;
        valid = 1'b0;
    endtask
    task automatic addr(input logic [6:0] a, input logic dir, input logic nak);
        i_ctrl.start();
        exp_q.push_back({8'hFF, 1'b1, 7'h00, nak});
        i_ctrl.wr_byte({a, dir});
    endtask
    task automatic fetch(input int n);
        logic [1:0]  st;
        logic [31:0] pk;
        logic [7:0]  care;
        st = fault_diag ? 2'h3 : fault_invalid ? 2'h1 : (meas_busy || !fresh) ? 2'h2 : 2'h0;
        pk = {st, meas_pressure, meas_temp, 5'h00};
        addr(dev_addr, 1'b1, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            care = (i == 3) ? 8'hE0 : 8'hFF;
            if (!valid)
                care = (i == 0) ? 8'hC0 : 8'h00;
            exp_q.push_back({care, 1'b0, pk[31-8*i -: 8]});
            i_ctrl.rd_byte(i == n - 1);
        end
        if (sleep_mode && n < 4)
            exp_m.push_back(1'b1);
        i_ctrl.stop();
        fresh = 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task automatic wreq(input logic wd);
        addr(dev_addr, 1'b0, 1'b0);
        if (wd)
        begin
            exp_q.push_back({8'hFF, 9'h100});
            i_ctrl.wr_byte(8'($urandom));
        end
        exp_m.push_back(1'b0);
        i_ctrl.stop();
        repeat (8) @(posedge clk);
    endtask
    task automatic meas();
        meas_pressure <= 14'($urandom);
        meas_temp <= 11'($urandom);
        meas_done <= 1'b1;
        @(posedge clk);
        meas_done <= 1'b0;
        @(posedge clk);
        fresh = 1'b1;
        valid = 1'b1;
    endtask
    // ****
    // Result watcher
    // ****
    always @(posedge clk)
    begin
        cycles++;
        if (got_stb)
        begin
            nt = (exp_q.size() > 0) ? exp_q.pop_front() : {8'h00, 9'h0FF};
            msk = {1'b1, nt[16:9]};
            check(got_val & msk, nt[8:0] & msk);
        end
        if (meas_start)
            check({8'h00, meas_kind}, (exp_m.size() > 0) ? {8'h00, exp_m.pop_front()} : 9'h1FF);
        if (cycles == 40000)
        begin
            mismatches++;
            $display("mismatch at %0t: run too long", $time);
            finish_test();
        end
    end
    initial
    begin
        seed = $urandom(65871);
        do_reset();
        fetch(0);
        fetch(2);
        meas();
        fetch(4);
        fetch(3);
        meas();
        fetch(2);
        wreq(1'b0);
        meas();
        fetch(4);
        wreq(1'b1);
        addr(dev_addr ^ 7'h01, 1'b1, 1'b1);
        i_ctrl.stop();
        for (int k = 0; k < 4; k++)
        begin
            {meas_busy, fault_invalid, fault_diag} <= tbl[k];
            meas();
            fetch(2);
        end
        {meas_busy, fault_invalid, fault_diag} <= 3'b000;
        sleep_mode <= 1'b0;
        meas();
        fetch(3);
        sleep_mode <= 1'b1;
        do_reset();
        wreq(1'b0);
        meas();
        fetch(4);
        finish_test();
    end
endmodule // testbench
